// File: sob_pkg.sv
// Purpose: Shared constants, types and decoding for the static option byte loader
// Assumes: One clock; option bytes held in a small non-volatile store model
// Notes:   Decode function is shared by the reset defaults and the reset-time load
// Operation
// - Option bytes have no bus address; reachable only in programming mode
// - Erased option byte reads as all ones
// - Shipped content selects internal RC oscillator for in-circuit programming
// - Byte0 bit7 set: halt entry with active watchdog resets device
// - Byte0 bit6: 0 watchdog always on, 1 software enables it
// - Byte0 bits 4:3 choose detector threshold or detectors off
// - Byte0 bit0 low blocks program readout and flash writes
// - Erasing protected option bytes erases user memory first
// - Byte1 bit6 picks 4096 or 256 cycle reset phase, also halt exit
// - Byte1 bits 5:4 choose main clock source
// - Byte1 bit0 low enables clock doubler
package sob_pkg;

  // ---------------------------------------------------------------
  // Option byte field positions
  // ---------------------------------------------------------------
  localparam int OB0_HALT_RST = 7;
  localparam int OB0_WDG_TYPE = 6;
  localparam int OB0_DET_HI   = 4;
  localparam int OB0_DET_LO   = 3;
  localparam int OB0_RDP      = 0;
  localparam int OB1_RST_LEN  = 6;
  localparam int OB1_CLK_HI   = 5;
  localparam int OB1_CLK_LO   = 4;
  localparam int OB1_RNG_HI   = 3;
  localparam int OB1_RNG_LO   = 1;
  localparam int OB1_PLL_OFF  = 0;

  // ---------------------------------------------------------------
  // Store contents
  // ---------------------------------------------------------------
  localparam logic [7:0] OB_ERASED = 8'hFF;
  localparam logic [7:0] OB0_SHIP  = 8'hE7;
  localparam logic [7:0] OB1_SHIP  = 8'hEF;

  // ---------------------------------------------------------------
  // Reset phase lengths in processor cycles
  // ---------------------------------------------------------------
  localparam int         RST_CNT_W     = 13;
  localparam logic [12:0] RST_LONG_CYC  = 13'h1000;
  localparam logic [12:0] RST_SHORT_CYC = 13'h0100;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS    = 8'h04;
  localparam int         CTRL_WDG_EN = 0;
  localparam int         STAT_WDG    = 12;
  localparam int         STAT_HOLD   = 13;
  localparam int         STAT_LOADED = 14;
  localparam int         CFG_W       = 12;

  typedef enum logic [1:0] {
    DET_HIGH = 2'b00,
    DET_MED  = 2'b01,
    DET_LOW  = 2'b10,
    DET_OFF  = 2'b11
  } sob_det_e;

  typedef enum logic [1:0] {
    CLK_RESONATOR = 2'b00,
    CLK_RSVD      = 2'b01,
    CLK_RC        = 2'b10,
    CLK_EXT       = 2'b11
  } sob_clk_e;

  typedef enum logic [1:0] {
    NV_IDLE       = 2'b00,
    NV_USER_ERASE = 2'b01,
    NV_OPT_ERASE  = 2'b10
  } sob_nv_e;

  typedef struct packed {
    logic       halt_entry_watchdog_reset;
    logic       watchdog_type_select;
    sob_det_e   voltage_detect_level;
    logic       readout_protect;
    logic       reset_phase_length;
    sob_clk_e   clock_source_type;
    logic [2:0] oscillator_range;
    logic       pll_en;
  } sob_cfg_s;

  function automatic sob_cfg_s sob_decode(input logic [7:0] b0, input logic [7:0] b1);
    sob_cfg_s c;
    c.halt_entry_watchdog_reset = b0[OB0_HALT_RST];
    c.watchdog_type_select      = b0[OB0_WDG_TYPE];
    c.voltage_detect_level      = sob_det_e'(b0[OB0_DET_HI:OB0_DET_LO]);
    // Protection active when the bit is cleared
    c.readout_protect           = ~b0[OB0_RDP];
    c.reset_phase_length        = b1[OB1_RST_LEN];
    c.clock_source_type         = sob_clk_e'(b1[OB1_CLK_HI:OB1_CLK_LO]);
    c.oscillator_range          = b1[OB1_RNG_HI:OB1_RNG_LO];
    c.pll_en                    = ~b1[OB1_PLL_OFF];
    return c;
  endfunction

endpackage

// File: sob_rst_phase.sv
// Purpose: Reset phase counter holding the core for a selected number of cycles
// Assumes: i_start is a one-cycle pulse on i_clk
// Notes:   A new start restarts the count from the full length
module sob_rst_phase #(
  parameter logic [12:0] LONG_CYC  = sob_pkg::RST_LONG_CYC,
  parameter logic [12:0] SHORT_CYC = sob_pkg::RST_SHORT_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Control
  input  wire logic i_start,
  input  wire logic i_short,
  // Status
  output logic      o_busy
);

  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic [12:0] len_sel;

  assign len_sel = i_short ? SHORT_CYC : LONG_CYC;
  assign cnt_nxt = i_start ? len_sel : ((cnt_r != 13'h0000) ? cnt_r - 13'h0001 : cnt_r);
  assign o_busy  = (cnt_r != 13'h0000);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 13'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [12:0] run_r;
  logic        short_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_r   <= 13'h0000;
      short_r <= 1'b0;
    end else begin
      run_r   <= i_start ? 13'h0000 : (o_busy ? run_r + 13'h0001 : run_r);
      short_r <= i_start ? i_short : short_r;
    end
  end

  a_phase_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_busy) |-> run_r == (short_r ? SHORT_CYC : LONG_CYC))
    else $error("reset phase length wrong");

endmodule // sob_rst_phase

// File: sob_option_cfg.sv
// Purpose: Static option byte store, reset-time loader, decoder and AHB-Lite status
// Assumes: Programming port strobes are synchronous to i_clk; i_prog_mode is a pin
// Notes:   Store survives i_rst_b; an erase clears it to all ones and i_por_b reloads the shipped content
module sob_option_cfg (
  // Clock and resets
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_por_b,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Programming tool port
  input  wire logic              i_prog_mode,
  input  wire logic              i_prog_rd,
  input  wire logic              i_prog_wr,
  input  wire logic              i_prog_erase,
  input  wire logic              i_prog_sel,
  input  wire logic [7:0]        i_prog_wdata,
  output logic      [7:0]        o_prog_rdata,
  output logic                   o_prog_ack,
  output logic                   o_prog_busy,
  // User memory erase handshake
  output logic                   o_user_erase_req,
  input  wire logic              i_user_erase_done,
  // Core and system control
  input  wire logic              i_halt_entry,
  input  wire logic              i_halt_exit,
  output logic                   o_halt_reset,
  output logic                   o_core_rst_hold,
  output logic                   o_wdg_active,
  output logic                   o_flash_wr_block,
  output logic                   o_readout_block,
  output logic                   o_supply_detect_en,
  output sob_pkg::sob_cfg_s      o_cfg
);

  // ---------------------------------------------------------------
  // Programming mode pin synchroniser
  // ---------------------------------------------------------------
  logic mode_s1_r;
  logic mode_s2_r;
  logic mode_s3_r;
  logic mode_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
      mode_s3_r <= 1'b0;
      mode_r    <= 1'b0;
    end else begin
      mode_s1_r <= i_prog_mode;
      mode_s2_r <= mode_s1_r;
      mode_s3_r <= mode_s2_r;
      mode_r    <= (mode_s2_r == mode_s3_r) ? mode_s3_r : mode_r;
    end
  end

  // ---------------------------------------------------------------
  // Non-volatile store and programming sequencer
  // ---------------------------------------------------------------
  logic [7:0]       nv_r [2];
  sob_pkg::sob_nv_e nv_st_r;
  sob_pkg::sob_nv_e nv_st_nxt;
  logic             touched_r;
  logic             ack_r;
  logic [7:0]       rdata_r;
  logic             req_r;

  wire nv_idle   = (nv_st_r == sob_pkg::NV_IDLE);
  wire prot_now  = ~nv_r[0][sob_pkg::OB0_RDP];
  wire prog_ok   = mode_r & nv_idle;
  wire do_rd     = prog_ok & i_prog_rd;
  // Writes are refused while protected; only an erase or i_por_b lifts protection
  wire do_wr     = prog_ok & i_prog_wr & ~i_prog_rd & ~prot_now;
  wire do_erase  = prog_ok & i_prog_erase & ~i_prog_rd & ~i_prog_wr;
  wire opt_clear = (nv_st_r == sob_pkg::NV_OPT_ERASE);

  // when protected, user memory erased before option bytes
  always_comb begin
    nv_st_nxt = nv_st_r;
    case (nv_st_r)
      sob_pkg::NV_IDLE: begin
        if (do_erase) begin
          nv_st_nxt = prot_now ? sob_pkg::NV_USER_ERASE : sob_pkg::NV_OPT_ERASE;
        end
      end
      sob_pkg::NV_USER_ERASE: begin
        if (i_user_erase_done) begin
          nv_st_nxt = sob_pkg::NV_OPT_ERASE;
        end
      end
      sob_pkg::NV_OPT_ERASE: begin
        nv_st_nxt = sob_pkg::NV_IDLE;
      end
      default: begin
        nv_st_nxt = sob_pkg::NV_IDLE;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_nv
      always_ff @(posedge i_clk or negedge i_por_b) begin
        if (!i_por_b) begin
          nv_r[gi] <= (gi == 0) ? sob_pkg::OB0_SHIP : sob_pkg::OB1_SHIP;
        end else if (opt_clear) begin
          nv_r[gi] <= sob_pkg::OB_ERASED;
        end else if (do_wr && (i_prog_sel == 1'(gi))) begin
          nv_r[gi] <= i_prog_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_por_b) begin
    if (!i_por_b) begin
      touched_r <= 1'b0;
    end else begin
      touched_r <= touched_r | do_wr | opt_clear;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nv_st_r <= sob_pkg::NV_IDLE;
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
      req_r   <= 1'b0;
    end else begin
      nv_st_r <= nv_st_nxt;
      ack_r   <= do_rd | do_wr | opt_clear;
      rdata_r <= do_rd ? nv_r[i_prog_sel] : rdata_r;
      req_r   <= (nv_st_nxt == sob_pkg::NV_USER_ERASE);
    end
  end

  assign o_prog_rdata     = rdata_r;
  assign o_prog_ack       = ack_r;
  assign o_prog_busy      = ~nv_idle;
  assign o_user_erase_req = req_r;

  // ---------------------------------------------------------------
  // Reset-time load of the decoded settings
  // ---------------------------------------------------------------
  localparam sob_pkg::sob_cfg_s CFG_RST = sob_pkg::sob_decode(sob_pkg::OB0_SHIP,
                                                              sob_pkg::OB1_SHIP);
  sob_pkg::sob_cfg_s cfg_r;
  logic              loaded_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r    <= CFG_RST;
      loaded_r <= 1'b0;
    end else if (!loaded_r) begin
      cfg_r    <= sob_pkg::sob_decode(nv_r[0], nv_r[1]);
      loaded_r <= 1'b1;
    end
  end

  assign o_cfg = cfg_r;

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  logic ctrl_wdg_r;
  logic halt_rst_r;

  assign o_wdg_active     = loaded_r & (~cfg_r.watchdog_type_select | ctrl_wdg_r);
  assign o_supply_detect_en = loaded_r & (cfg_r.voltage_detect_level != sob_pkg::DET_OFF);
  assign o_flash_wr_block = cfg_r.readout_protect;
  assign o_readout_block  = cfg_r.readout_protect;

  wire halt_rst_nxt = i_halt_entry & o_wdg_active & cfg_r.halt_entry_watchdog_reset;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      halt_rst_r <= 1'b0;
    end else begin
      halt_rst_r <= halt_rst_nxt;
    end
  end

  assign o_halt_reset = halt_rst_r;

  // reset phase after load and on halt exit
  wire phase_start = (~loaded_r) | i_halt_exit;
  wire phase_busy;

  sob_rst_phase u_phase (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_start (phase_start),
    .i_short (loaded_r ? cfg_r.reset_phase_length : nv_r[1][sob_pkg::OB1_RST_LEN]),
    .o_busy  (phase_busy)
  );

  assign o_core_rst_hold = ~loaded_r | phase_busy;

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  logic        dp_wr_r;
  logic [7:0]  dp_addr_r;
  logic [31:0] hrdata_r;

  wire        ap_take  = i_hsel & i_hready & i_htrans[1];
  wire        ap_read  = ap_take & ~i_hwrite;
  wire [7:0]  ap_addr  = i_haddr[7:0];
  wire        wr_ctrl  = dp_wr_r & (dp_addr_r == sob_pkg::CTRL_OFS);
  // Forward a pending control write to a read that follows back to back
  wire        ctrl_val = wr_ctrl ? i_hwdata[sob_pkg::CTRL_WDG_EN] : ctrl_wdg_r;
  wire [31:0] stat_val = {17'h00000, loaded_r, o_core_rst_hold, o_wdg_active, cfg_r};
  wire [31:0] ctrl_rd  = {31'h00000000, ctrl_val};
  wire [31:0] rd_mux   = (ap_addr == sob_pkg::CTRL_OFS) ? ctrl_rd :
                         (ap_addr == sob_pkg::STAT_OFS) ? stat_val : 32'h00000000;
  wire        map_hit  = (i_haddr[31:8] == 24'h000000);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dp_wr_r    <= 1'b0;
      dp_addr_r  <= 8'h00;
      hrdata_r   <= 32'h00000000;
      ctrl_wdg_r <= 1'b0;
    end else begin
      dp_wr_r    <= ap_take & i_hwrite & map_hit;
      dp_addr_r  <= ap_take ? ap_addr : dp_addr_r;
      hrdata_r   <= ap_read ? (map_hit ? rd_mux : 32'h00000000) : hrdata_r;
      ctrl_wdg_r <= ctrl_val;
    end
  end

  assign o_hrdata    = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_prog_mode_only: assert property (
    o_prog_ack |-> $past(mode_r))
    else $error("option access outside programming mode");

  a_erase_ones: assert property (
    $past(opt_clear) |-> (nv_r[0] == sob_pkg::OB_ERASED) && (nv_r[1] == sob_pkg::OB_ERASED))
    else $error("erased option byte not all ones");

  a_ship_rc_clock: assert property (
    $rose(loaded_r) && !touched_r |-> cfg_r.clock_source_type == sob_pkg::CLK_RC)
    else $error("shipped content not RC clock");

  a_halt_reset_on: assert property (
    halt_rst_nxt |=> o_halt_reset)
    else $error("halt entry reset missing");

  a_halt_reset_off: assert property (
    !cfg_r.halt_entry_watchdog_reset |=> !o_halt_reset)
    else $error("halt reset with option clear");

  a_hw_watchdog: assert property (
    loaded_r && !cfg_r.watchdog_type_select |-> o_wdg_active)
    else $error("hardware watchdog not active");

  a_sw_watchdog: assert property (
    loaded_r && cfg_r.watchdog_type_select && !ctrl_wdg_r |-> !o_wdg_active)
    else $error("software watchdog active unasked");

  a_detect_off: assert property (
    loaded_r |-> o_supply_detect_en == (cfg_r.voltage_detect_level != sob_pkg::DET_OFF))
    else $error("detector enable mismatch");

  a_protect_block: assert property (
    $rose(loaded_r) |-> o_flash_wr_block == !$past(nv_r[0][sob_pkg::OB0_RDP]))
    else $error("protection block mismatch");

  a_user_first: assert property (
    do_erase && prot_now |=> o_user_erase_req && $stable(nv_r[0]))
    else $error("option erase before user erase");

  a_clock_source: assert property (
    $rose(loaded_r) |-> cfg_r.clock_source_type ==
      $past(nv_r[1][sob_pkg::OB1_CLK_HI:sob_pkg::OB1_CLK_LO]))
    else $error("clock source decode wrong");

  a_doubler: assert property (
    $rose(loaded_r) |-> cfg_r.pll_en == !$past(nv_r[1][sob_pkg::OB1_PLL_OFF]))
    else $error("doubler decode wrong");

  a_cfg_held: assert property (
    loaded_r && $past(loaded_r) |-> $stable(cfg_r))
    else $error("settings changed before reset");

  c_halt_reset:  cover property (o_halt_reset);
  c_user_erase:  cover property (o_user_erase_req ##[1:50] opt_clear);
  c_prog_write:  cover property (do_wr ##1 o_prog_ack);
  c_sw_wdg:      cover property (cfg_r.watchdog_type_select && o_wdg_active);

endmodule // sob_option_cfg

// File: sob_prog_tool.sv
// Purpose: Behavioural programming tool driving the option byte programming port
// Assumes: Port strobes are sampled on i_clk rising edges; one strobe per request
// Notes:   Answers the user memory erase request DONE_DLY + 1 cycles after it rises
module sob_prog_tool #(
  parameter int DONE_DLY = 4
) (
  // Clock
  input  wire logic       i_clk,
  // Programming strobes
  output logic            o_rd,
  output logic            o_wr,
  output logic            o_erase,
  output logic            o_sel,
  output logic [7:0]      o_wdata,
  // Device answers
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_ack,
  input  wire logic       i_erase_req,
  output logic            o_erase_done,
  output logic            o_saw_req
);
  timeunit 1ns;
  timeprecision 1ps;

  int wait_cnt;

  initial begin
    {o_rd, o_wr, o_erase, o_sel, o_erase_done, o_saw_req} = 6'h00;
    o_wdata  = 8'h00;
    wait_cnt = 0;
  end

  // ---------------------------------------------------------------
  // Request: kind 0 read, 1 write, 2 erase
  // ---------------------------------------------------------------
  task automatic op(input int kind, input logic sel, input logic [7:0] d,
                    output logic got, output logic [7:0] q);
    int n;
    @(posedge i_clk);
    o_rd    <= (kind == 0);
    o_wr    <= (kind == 1);
    o_erase <= (kind == 2);
    o_sel   <= sel;
    o_wdata <= sel ? d : {d[7:6], 1'b1, d[4:3], 2'b11, d[0]};
    @(posedge i_clk);
    {o_rd, o_wr, o_erase} <= 3'h0;
    // Released data never shows the last value
    o_wdata <= ~o_wdata;
    got = 1'b0;
    q   = 8'h00;
    for (n = 0; n < 64; n++) begin
      // Look once the answer has settled after the edge
      #1;
      if (i_ack === 1'b1) begin
        got = 1'b1;
        q   = i_rdata;
        break;
      end
      @(posedge i_clk);
    end
  endtask

  // ---------------------------------------------------------------
  // User memory erase, answered slowly
  // ---------------------------------------------------------------
  // user erase before option erase
  always @(posedge i_clk) begin
    if (i_erase_req === 1'b1) begin
      wait_cnt     <= wait_cnt + 1;
      o_saw_req    <= 1'b1;
      o_erase_done <= (wait_cnt >= DONE_DLY);
    end else begin
      wait_cnt     <= 0;
      o_erase_done <= 1'b0;
    end
  end
endmodule // sob_prog_tool

// File: sob_tb.sv
// Purpose: Self-checking bench for the option byte loader
// Assumes: Zero wait state slave; settings load on the first edge after reset
// Notes:   Reset phase lengths are checked to the exact cycle
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              i_clk, i_rst_b, i_por_b, hsel, hwrite, prog_mode, halt_in, halt_ex;
  logic [31:0]       haddr, hwdata, hrdata, r;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              hready, hresp, rd, wr, er, sel, ack, busy, ureq, udone, saw;
  logic              halt_rst, hold, wdg, fwb, rob, sdet, got;
  logic [7:0]        wd, rdat, q, b0, b1;
  sob_pkg::sob_cfg_s cfg;
  logic [11:0]       keep;
  int                mismatches, comparisons;

  sob_option_cfg sob_option_cfg_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_prog_mode(prog_mode),
    .i_prog_rd(rd), .i_prog_wr(wr), .i_prog_erase(er), .i_prog_sel(sel),
    .i_prog_wdata(wd), .o_prog_rdata(rdat), .o_prog_ack(ack), .o_prog_busy(busy),
    .o_user_erase_req(ureq), .i_user_erase_done(udone), .i_halt_entry(halt_in),
    .i_halt_exit(halt_ex), .o_halt_reset(halt_rst), .o_core_rst_hold(hold),
    .o_wdg_active(wdg), .o_flash_wr_block(fwb), .o_readout_block(rob),
    .o_supply_detect_en(sdet), .o_cfg(cfg)
  );

  sob_prog_tool sob_prog_tool_i (
    .i_clk(i_clk), .o_rd(rd), .o_wr(wr), .o_erase(er), .o_sel(sel), .o_wdata(wd),
    .i_rdata(rdat), .i_ack(ack), .i_erase_req(ureq), .o_erase_done(udone),
    .o_saw_req(saw)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] exp_cfg(input logic [7:0] a, input logic [7:0] c);
    return {a[7], a[6], a[4:3], ~a[0], c[6], c[5:4], c[3:1], ~c[0]};
  endfunction

  task print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task wait_rdy;
    int n;
    for (n = 0; n < 32; n++) begin
      @(posedge i_clk);
      if (hready === 1'b1) return;
    end
    mismatches++;
    print_verdict();
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] rv);
    @(posedge i_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic measure(input int n);
    int c;
    c = 0;
    repeat (5000) begin
      @(posedge i_clk);
      #1;
      if (hold === 1'b1) c++;
      else break;
    end
    `CHK(c, n)
  endtask

  task go_reset(input logic por, input int n);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    if (por) i_por_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    i_por_b <= 1'b1;
    measure(n);
  endtask

  task halt_chk(input logic e);
    @(posedge i_clk);
    halt_in <= 1'b1;
    @(posedge i_clk);
    halt_in <= 1'b0;
    #1;
    `CHK(halt_rst, e)
  endtask

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    {i_rst_b, i_por_b, hsel, hwrite, prog_mode, halt_in, halt_ex} = 7'h00;
    {haddr, hwdata} = 64'h0;
    htrans      = 2'h0;
    hsize       = 3'h2;
    mismatches  = 0;
    comparisons = 0;
    go_reset(1'b1, 256);
    `CHK(cfg, exp_cfg(8'hE7, 8'hEF))
    `CHK(cfg.clock_source_type, sob_pkg::CLK_RC)
    ahb(1'b0, 32'h4, 32'h0, r);
    `CHK(r[14:0], {3'h4, exp_cfg(8'hE7, 8'hEF)})
    `CHK(wdg, 1'b0)
    halt_chk(1'b0);
    ahb(1'b1, 32'h0, 32'h1, r);
    ahb(1'b0, 32'h0, 32'h0, r);
    `CHK(r, 32'h1)
    `CHK(wdg, 1'b1)
    halt_chk(1'b1);
    ahb(1'b1, 32'h0, 32'h0, r);
    halt_chk(1'b0);
    ahb(1'b1, 32'h8, 32'hFFFFFFFF, r);
    ahb(1'b0, 32'h8, 32'h0, r);
    `CHK(r, 32'h0)
    sob_prog_tool_i.op(0, 1'b0, 8'h00, got, q);
    `CHK(got, 1'b0)
    @(posedge i_clk);
    prog_mode <= 1'b1;
    repeat (6) @(posedge i_clk);
    sob_prog_tool_i.op(0, 1'b0, 8'h00, got, q);
    `CHK(q, 8'hE7)
    sob_prog_tool_i.op(0, 1'b1, 8'h00, got, q);
    `CHK(q, 8'hEF)
    sob_prog_tool_i.op(2, 1'b0, 8'h00, got, q);
    `CHK(got, 1'b1)
    sob_prog_tool_i.op(0, 1'b1, 8'h00, got, q);
    `CHK(q, 8'hFF)
    for (int i = 0; i < 4; i++) begin
      b0   = {i[0], i[1], 1'b1, 2'(i), 2'h3, 1'b1};
      b1   = {2'h3, 2'(i), 3'(i), i[0]};
      keep = cfg;
      sob_prog_tool_i.op(1, 1'b0, b0, got, q);
      sob_prog_tool_i.op(1, 1'b1, b1, got, q);
      `CHK(cfg, keep)
      go_reset(1'b0, 256);
      `CHK(cfg, exp_cfg(b0, b1))
      `CHK(sdet, 1'(i != 3))
      `CHK(wdg, ~i[1])
      halt_chk(i[0] & ~i[1]);
    end
    sob_prog_tool_i.op(1, 1'b1, 8'hAF, got, q);
    go_reset(1'b0, 4096);
    @(posedge i_clk);
    halt_ex <= 1'b1;
    @(posedge i_clk);
    halt_ex <= 1'b0;
    // One held cycle passes while the exit pulse is lowered
    measure(4096 - 1);
    sob_prog_tool_i.op(1, 1'b0, 8'hE6, got, q);
    go_reset(1'b0, 4096);
    `CHK({rob, fwb}, 2'h3)
    sob_prog_tool_i.op(1, 1'b1, 8'hEF, got, q);
    `CHK(got, 1'b0)
    sob_prog_tool_i.op(0, 1'b1, 8'h00, got, q);
    `CHK(q, 8'hAF)
    sob_prog_tool_i.op(2, 1'b0, 8'h00, got, q);
    `CHK({got, saw, busy}, 3'h6)
    sob_prog_tool_i.op(0, 1'b0, 8'h00, got, q);
    `CHK(q, 8'hFF)
    sob_prog_tool_i.op(1, 1'b0, 8'hE7, got, q);
    `CHK(got, 1'b1)
    go_reset(1'b0, 256);
    `CHK(rob, 1'b0)
    print_verdict();
  end
endmodule // testbench
